// *** common/scc_pkg.sv ***
// shared constants and types for the charger command link
package scc_pkg;
  // link timing
  localparam int SYS_HZ = 25_000_000;
  localparam int SCL_HZ = 100_000;
  localparam int QUARTER_CYC = SYS_HZ / (4 * SCL_HZ);
  // bus address and command codes
  localparam logic [6:0] DEV_ADDR = 7'h09;
  localparam logic [7:0] CMD_CHARGE_OPTION = 8'h12;
  localparam logic [7:0] CMD_CHARGE_CURRENT = 8'h14;
  localparam logic [7:0] CMD_CHARGE_VOLTAGE = 8'h15;
  localparam logic [7:0] CMD_INPUT_CURRENT = 8'h3F;
  localparam logic [7:0] CMD_MAKER_ID = 8'hFE;
  localparam logic [7:0] CMD_PART_ID = 8'hFF;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // host register map
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_CMD = 3'h1;
  localparam logic [2:0] REG_WDATA = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_RDATA = 3'h4;
  localparam int CTRL_GO = 0;
  localparam int CTRL_READ = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RX_ACK, DS_TX, DS_TX_ACK} scc_dev_state_t;
  typedef enum logic [1:0] {HS_IDLE, HS_START, HS_BIT, HS_STOP} scc_host_state_t;
endpackage

// *** common/scc_link_if.sv ***
// open-drain clock and data lines between host and charger
`timescale 1ns/1ps
interface scc_link_if;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;
  // wired-and of every enabled driver, pull-up otherwise
  assign scl = !(!host_scl_oe_n && !host_scl_o);
  assign sda = !((!host_sda_oe_n && !host_sda_o) || (!dev_sda_oe_n && !dev_sda_o));
  modport host(output host_scl_o, host_scl_oe_n, host_sda_o, host_sda_oe_n, input scl, sda);
  modport dev(output dev_sda_o, dev_sda_oe_n, input scl, sda);
endinterface

// *** verilog/scc_sync2.sv ***
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module scc_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '1;
      q <= '1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule

// *** verilog/scc_device_end.sv ***
// charger command slave on the link clock
//
// Overview of operation
// - answer only address 0x12, never initiate
// - only word-write and word-read transfers
// - identity words readable at FF and FE
// - bus dead unless supply and adapter valid
// - start: data falls while clock high
// - stop: data rises while clock high
// - data changes only while clock low
// - bytes MSB first, sampled on clock rise
// - nine clocks per byte, receiver acknowledges
// - write order: addr, cmd, low, high, stop
// - accept commands 14, 15, 3F, 12
// - after stop return idle, await start
// - acknowledge is data held low on ninth
// - read: cmd, restart, low, high, host nack
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
module scc_device_end
  import scc_pkg::*;
#(
  // arbitrary identity values
  parameter logic [15:0] PART_ID = 16'h0A01,
  parameter logic [15:0] MAKER_ID = 16'h0050
) (
  input wire logic link_clk,
  input wire logic reset_n,
  scc_link_if.dev link,
  input wire logic supply_above_lockout,
  input wire logic adapter_detect_input,
  output logic [15:0] charge_current_setting,
  output logic [15:0] charge_voltage_setting,
  output logic [15:0] input_current_setting,
  output logic [15:0] charger_option_word,
  output logic bus_enabled
);
  scc_dev_state_t state;
  logic [3:0] pins_s;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic [7:0] shift;
  logic [3:0] cnt;
  logic [1:0] byte_no;
  logic rd_mode;
  logic tx_hi;
  logic host_ack;
  logic [7:0] cmd;
  logic [7:0] low_byte;
  logic commit;
  logic sda_oe_n;
  logic [15:0] rd_word;

  scc_sync2 #(.W(4)) u_sync (
    .clk(link_clk),
    .reset_n(reset_n),
    .d({link.scl, link.sda, supply_above_lockout, adapter_detect_input}),
    .q(pins_s)
  );

  assign scl_s = pins_s[3];
  assign sda_s = pins_s[2];
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = sda_oe_n;

  // line history for edge and condition detection
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise = scl_s && !scl_d;
  assign scl_fall = !scl_s && scl_d;
  assign start_ev = scl_s && scl_d && sda_d && !sda_s;
  assign stop_ev = scl_s && scl_d && !sda_d && sda_s;

  // enable follows supply and adapter levels
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_enabled <= 1'b0;
    end else begin
      bus_enabled <= pins_s[1] && pins_s[0];
    end
  end

  // word returned on a read
  always_comb begin
    case (cmd)
      CMD_CHARGE_CURRENT: rd_word = charge_current_setting;
      CMD_CHARGE_VOLTAGE: rd_word = charge_voltage_setting;
      CMD_INPUT_CURRENT: rd_word = input_current_setting;
      CMD_CHARGE_OPTION: rd_word = charger_option_word;
      CMD_MAKER_ID: rd_word = MAKER_ID;
      CMD_PART_ID: rd_word = PART_ID;
      default: rd_word = WORD_RESET;
    endcase
  end

  // protocol engine; sda only moves right after a clock fall
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= DS_IDLE;
      shift <= 8'h00;
      cnt <= 4'h0;
      byte_no <= 2'h0;
      rd_mode <= 1'b0;
      tx_hi <= 1'b0;
      host_ack <= 1'b0;
      cmd <= 8'h00;
      low_byte <= 8'h00;
      commit <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      commit <= 1'b0;
      if (!bus_enabled || stop_ev) begin
        state <= DS_IDLE;
        sda_oe_n <= 1'b1;
      end else if (start_ev) begin
        state <= DS_RX;
        cnt <= 4'h0;
        byte_no <= 2'h0;
        sda_oe_n <= 1'b1;
      end else begin
        case (state)
          DS_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          DS_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == 4'h8) begin
              cnt <= 4'h0;
              case (byte_no)
                2'h0: begin
                  if (shift[7:1] == DEV_ADDR) begin
                    rd_mode <= shift[0];
                    sda_oe_n <= 1'b0;
                    state <= DS_RX_ACK;
                  end else begin
                    state <= DS_IDLE;
                  end
                end
                2'h1: begin
                  cmd <= shift;
                  sda_oe_n <= 1'b0;
                  state <= DS_RX_ACK;
                end
                2'h2: begin
                  low_byte <= shift;
                  sda_oe_n <= 1'b0;
                  state <= DS_RX_ACK;
                end
                default: begin
                  commit <= 1'b1;
                  sda_oe_n <= 1'b0;
                  state <= DS_RX_ACK;
                end
              endcase
            end
          end
          DS_RX_ACK: begin
            if (scl_fall) begin
              cnt <= 4'h0;
              if (rd_mode) begin
                shift <= rd_word[7:0];
                tx_hi <= 1'b0;
                sda_oe_n <= rd_word[7];
                state <= DS_TX;
              end else if (byte_no == 2'h3) begin
                sda_oe_n <= 1'b1;
                state <= DS_IDLE;
              end else begin
                sda_oe_n <= 1'b1;
                byte_no <= byte_no + 2'h1;
                state <= DS_RX;
              end
            end
          end
          DS_TX: begin
            if (scl_rise) begin
              cnt <= cnt + 4'h1;
            end else if (scl_fall) begin
              if (cnt == 4'h8) begin
                sda_oe_n <= 1'b1;
                state <= DS_TX_ACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                sda_oe_n <= shift[6];
              end
            end
          end
          DS_TX_ACK: begin
            if (scl_rise) begin
              host_ack <= !sda_s;
            end else if (scl_fall) begin
              cnt <= 4'h0;
              if (host_ack && !tx_hi) begin
                tx_hi <= 1'b1;
                shift <= rd_word[15:8];
                sda_oe_n <= rd_word[15];
                state <= DS_TX;
              end else begin
                state <= DS_IDLE;
              end
            end
          end
          default: begin
            state <= DS_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // settings take a whole word at once
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      charge_current_setting <= WORD_RESET;
      charge_voltage_setting <= WORD_RESET;
      input_current_setting <= WORD_RESET;
      charger_option_word <= WORD_RESET;
    end else if (commit) begin
      case (cmd)
        CMD_CHARGE_CURRENT: charge_current_setting <= {shift, low_byte};
        CMD_CHARGE_VOLTAGE: charge_voltage_setting <= {shift, low_byte};
        CMD_INPUT_CURRENT: input_current_setting <= {shift, low_byte};
        CMD_CHARGE_OPTION: charger_option_word <= {shift, low_byte};
        default: charger_option_word <= charger_option_word;
      endcase
    end
  end
endmodule

// *** verilog/scc_host_end.sv ***
// bus master that issues word transfers on software command
`timescale 1ns/1ps
module scc_host_end
  import scc_pkg::*;
#(
  parameter int QUARTER = QUARTER_CYC
) (
  input wire logic sys_clk,
  input wire logic reset_n,
  scc_link_if.host link,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);
  scc_host_state_t state;
  logic line_s;
  logic [7:0] qcnt;
  logic tick;
  logic [1:0] phase;
  logic [2:0] step;
  logic [3:0] bitn;
  logic [7:0] tx;
  logic [7:0] rx;
  logic [7:0] cmd_code;
  logic [15:0] wdata;
  logic [15:0] rdata_word;
  logic op_read;
  logic nack;
  logic scl_oe_n;
  logic sda_oe_n;
  logic is_rx;
  logic last_step;
  logic go;
  logic [7:0] next_tx;

  scc_sync2 #(.W(1)) u_sync (
    .clk(sys_clk),
    .reset_n(reset_n),
    .d(link.sda),
    .q(line_s)
  );

  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe_n = scl_oe_n;
  assign link.host_sda_oe_n = sda_oe_n;
  assign tick = (qcnt == 8'(QUARTER - 1));
  // read address byte is still sent by the host, only the two data bytes come back
  assign is_rx = op_read && (step >= 3'h4);
  assign last_step = op_read ? (step == 3'h5) : (step == 3'h4);
  assign go = reg_wr && (reg_addr == REG_CTRL) && reg_wdata[CTRL_GO] && (state == HS_IDLE);

  // byte of the step that follows the current one
  always_comb begin
    case (step)
      3'h1: next_tx = cmd_code;
      3'h2: next_tx = op_read ? {DEV_ADDR, 1'b1} : wdata[7:0];
      default: next_tx = wdata[15:8];
    endcase
  end

  // quarter-bit timebase for the divided clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= tick ? 8'h00 : qcnt + 8'h01;
    end
  end

  // software-written order registers
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cmd_code <= 8'h00;
      wdata <= WORD_RESET;
      op_read <= 1'b0;
    end else if (reg_wr && state == HS_IDLE) begin
      if (reg_addr == REG_CMD) cmd_code <= reg_wdata[7:0];
      if (reg_addr == REG_WDATA) wdata <= reg_wdata;
      if (go) op_read <= reg_wdata[CTRL_READ];
    end
  end

  // read port, data one cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        REG_CMD: reg_rdata <= {8'h00, cmd_code};
        REG_WDATA: reg_rdata <= wdata;
        REG_STATUS: reg_rdata <= {14'h0000, nack, state != HS_IDLE};
        REG_RDATA: reg_rdata <= rdata_word;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // bit engine: ph0 set data, ph1 raise clock, ph2 sample, ph3 drop clock
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= HS_IDLE;
      phase <= 2'h0;
      step <= 3'h0;
      bitn <= 4'h0;
      tx <= 8'h00;
      rx <= 8'h00;
      rdata_word <= WORD_RESET;
      nack <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
    end else if (go) begin
      state <= HS_START;
      phase <= 2'h0;
      step <= 3'h1;
      nack <= 1'b0;
    end else if (tick && state != HS_IDLE) begin
      phase <= phase + 2'h1;
      case (state)
        HS_START: begin
          case (phase)
            2'h0: sda_oe_n <= 1'b1;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b0;
            default: begin
              scl_oe_n <= 1'b0;
              tx <= {DEV_ADDR, op_read && (step == 3'h3)};
              bitn <= 4'h0;
              state <= HS_BIT;
            end
          endcase
        end
        HS_BIT: begin
          case (phase)
            2'h0: begin
              if (bitn < 4'h8) sda_oe_n <= is_rx ? 1'b1 : tx[7];
              else sda_oe_n <= is_rx ? (step == 3'h5) : 1'b1;
            end
            2'h1: scl_oe_n <= 1'b1;
            2'h2: begin
              if (bitn < 4'h8) rx <= {rx[6:0], line_s};
              else if (!is_rx && line_s) nack <= 1'b1;
            end
            default: begin
              scl_oe_n <= 1'b0;
              tx <= {tx[6:0], 1'b0};
              bitn <= bitn + 4'h1;
              if (bitn == 4'h8) begin
                if (is_rx && step == 3'h4) rdata_word[7:0] <= rx;
                if (is_rx && step == 3'h5) rdata_word[15:8] <= rx;
                if (nack || last_step) begin
                  state <= HS_STOP;
                end else begin
                  step <= step + 3'h1;
                  tx <= next_tx;
                  bitn <= 4'h0;
                  if (op_read && step == 3'h2) state <= HS_START;
                end
              end
            end
          endcase
        end
        HS_STOP: begin
          case (phase)
            2'h0: sda_oe_n <= 1'b0;
            2'h1: scl_oe_n <= 1'b1;
            2'h2: sda_oe_n <= 1'b1;
            default: state <= HS_IDLE;
          endcase
        end
        default: state <= HS_IDLE;
      endcase
    end
  end
endmodule

// *** testbench/scc_link_assertions.sv ***
// wire-level checks on the charger command link
`timescale 1ns/1ps
module scc_link_checker (
  input wire logic link_clk,
  input wire logic reset_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic scl_q;
  logic sda_q;
  logic in_frame;
  logic [5:0] rise_cnt;
  logic start_ev;
  logic stop_ev;
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!reset_n);
  assign start_ev = scl_q && scl && sda_q && !sda;
  assign stop_ev = scl_q && scl && !sda_q && sda;
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      in_frame <= 1'b0;
    end else if (start_ev) begin
      in_frame <= 1'b1;
    end else if (stop_ev) begin
      in_frame <= 1'b0;
    end
  end
  // clock rises since the last start, modulo nine; a stop presets one for an idle start
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      rise_cnt <= 6'h01;
    end else if (start_ev) begin
      rise_cnt <= 6'h00;
    end else if (stop_ev) begin
      rise_cnt <= 6'h01;
    end else if (scl && !scl_q) begin
      rise_cnt <= (rise_cnt == 6'h09) ? 6'h01 : rise_cnt + 6'h01;
    end
  end
  sequence start_s;
    $past(scl) && scl && $fell(sda);
  endsequence
  sequence stop_s;
    $past(scl) && scl && $rose(sda);
  endsequence
  start_quiet_a: assert property (start_s |-> dev_sda_oe_n)
    else $error("device pulls data during a start");
  stop_idle_a: assert property (stop_s |=> dev_sda_oe_n [*8])
    else $error("device drives data after a stop");
  dev_change_low_a: assert property ($changed(dev_sda_oe_n) |-> !scl && !$past(scl, 2) && $past(scl, 7))
    else $error("device data changed outside the clock low phase");
  dev_stable_high_a: assert property (scl && $past(scl) |-> $stable(dev_sda_oe_n))
    else $error("device data moved while clock high");
  ack_hold_a: assert property ($fell(dev_sda_oe_n) |-> !sda [*8])
    else $error("device low level not held");
  no_initiate_a: assert property (!dev_sda_oe_n |-> in_frame)
    else $error("device drove data outside a transfer");
  frame_len_a: assert property (start_ev || stop_ev |-> rise_cnt == 6'h01)
    else $error("frame clock count not a multiple of nine");
  scl_high_a: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
endmodule

// *** testbench/smbus_charger_command_slave_tb.sv ***
// self-checking bench for the charger command link
`timescale 1ns/1ps
`define CHK(a, b) \
  begin \
    tests_run++; \
    if ((a) !== (b)) begin \
      num_errors++; \
      $display("mismatch at %0t: got %h expected %h", $time, a, b); \
    end \
  end
module smbus_charger_command_slave_tb
  import scc_pkg::*;
;
  localparam logic [15:0] PART_VAL = 16'h5A3C; // arbitrary value
  localparam logic [15:0] MAKER_VAL = 16'h00C3; // arbitrary value
  logic sys_clk = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  logic supply_above_lockout = 1'b1;
  logic adapter_detect_input = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [15:0] cur_w, volt_w, inp_w, opt_w;
  logic bus_enabled;
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] cmds [4] = '{CMD_CHARGE_CURRENT, CMD_CHARGE_VOLTAGE, CMD_INPUT_CURRENT, CMD_CHARGE_OPTION};
  logic [15:0] vals [4] = '{16'hA51C, 16'h3C07, 16'h0F80, 16'h8001};
  scc_link_if link_bus();
  always #20 sys_clk = ~sys_clk;
  always #7.5 link_clk = ~link_clk;
  scc_host_end #(.QUARTER(8)) u_scc_host_end (.sys_clk(sys_clk), .reset_n(reset_n), .link(link_bus),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  scc_device_end #(.PART_ID(PART_VAL), .MAKER_ID(MAKER_VAL)) u_scc_device_end (.link_clk(link_clk),
    .reset_n(reset_n), .link(link_bus), .supply_above_lockout(supply_above_lockout),
    .adapter_detect_input(adapter_detect_input), .charge_current_setting(cur_w),
    .charge_voltage_setting(volt_w), .input_current_setting(inp_w), .charger_option_word(opt_w),
    .bus_enabled(bus_enabled));
  scc_link_checker u_scc_link_checker (.link_clk(link_clk), .reset_n(reset_n),
    .host_scl_o(link_bus.host_scl_o), .host_scl_oe_n(link_bus.host_scl_oe_n),
    .host_sda_o(link_bus.host_sda_o), .host_sda_oe_n(link_bus.host_sda_oe_n),
    .dev_sda_o(link_bus.dev_sda_o), .dev_sda_oe_n(link_bus.dev_sda_oe_n), .scl(link_bus.scl), .sda(link_bus.sda));
  function automatic logic [15:0] word_of(input int i);
    case (i)
      0: word_of = cur_w;
      1: word_of = volt_w;
      2: word_of = inp_w;
      default: word_of = opt_w;
    endcase
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic xfer(input logic rd, input logic [7:0] cmd, input logic [15:0] wd, output logic [15:0] rdw,
                      output logic nack);
    logic [15:0] st;
    int n;
    reg_write(REG_CMD, {8'h00, cmd});
    reg_write(REG_WDATA, wd);
    reg_write(REG_CTRL, {14'h0000, rd, 1'b1});
    st = 16'h0001;
    n = 0;
    while (st[ST_BUSY] !== 1'b0 && n < 4000) begin
      reg_read(REG_STATUS, st);
      n++;
    end
    `CHK(st[ST_BUSY], 1'b0)
    nack = st[ST_NACK];
    reg_read(REG_RDATA, rdw);
  endtask
  task automatic wait_enable(input logic v);
    int n;
    n = 0;
    while (bus_enabled !== v && n < 100) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK(bus_enabled, v)
  endtask
  task automatic t_write_words();
    logic [15:0] r;
    logic nk;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, cmds[i], vals[i], r, nk);
      `CHK(nk, 1'b0)
      `CHK(word_of(i), vals[i])
    end
    for (int i = 0; i < 4; i++) `CHK(word_of(i), vals[i])
  endtask
  task automatic t_read_words();
    logic [15:0] r;
    logic nk;
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, cmds[i], 16'h0000, r, nk);
      `CHK(nk, 1'b0)
      `CHK(r, vals[i])
    end
    xfer(1'b1, CMD_PART_ID, 16'h0000, r, nk);
    `CHK(r, PART_VAL)
    xfer(1'b1, CMD_MAKER_ID, 16'h0000, r, nk);
    `CHK(r, MAKER_VAL)
  endtask
  task automatic t_id_write();
    logic [15:0] r;
    logic nk;
    xfer(1'b0, CMD_PART_ID, 16'hFFFF, r, nk);
    xfer(1'b1, CMD_PART_ID, 16'h0000, r, nk);
    `CHK(r, PART_VAL)
    for (int i = 0; i < 4; i++) `CHK(word_of(i), vals[i])
    xfer(1'b1, 8'h20, 16'h0000, r, nk);
    `CHK(r, WORD_RESET)
  endtask
  task automatic t_disabled();
    logic [15:0] r;
    logic nk;
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      supply_above_lockout <= (k != 0);
      adapter_detect_input <= (k == 0);
      wait_enable(1'b0);
      xfer(1'b0, cmds[0], 16'h1111, r, nk);
      `CHK(nk, 1'b1)
      `CHK(word_of(0), vals[0])
      @(posedge sys_clk);
      supply_above_lockout <= 1'b1;
      adapter_detect_input <= 1'b1;
      wait_enable(1'b1);
    end
  endtask
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    wait_enable(1'b1);
    t_write_words();
    t_read_words();
    t_id_write();
    t_disabled();
    wrap_up();
  end
endmodule
